// >>> design/oag_pkg.sv
// Contract
// - sixteen 32-bit general registers, numbered 0-15
// - register 15 is the program counter
// - register 14 is the stack pointer
// - register 13 is the call frame pointer
// - register 12 is the argument list pointer
// - one/two byte opcode, zero to six specifiers
// - pc holds instruction start when execution begins; here pc is past the opcode and all specifier bytes by then
// - status longword low half user, high privileged
// - user word holds condition codes, trap enables
// - detect overflow, divide by zero, underflow, trace
// - exception saves state and traps to handler
// - mode 0 operand is the register
// - mode 1 register holds operand address
// - mode 2 predecrement by size, then address
// - mode 3 address then postincrement by size
// - mode 4 read pointer, register plus four
// - mode 5 register plus signed displacement
// - indexed variant adds index times size
// - mode 6 displacement sum addresses pointer
// - literal gives unsigned six-bit constant
package oag_pkg;
   localparam int unsigned REG_W = 32;
   localparam int unsigned REG_N = 16;
   localparam logic [3:0] REG_PC = 4'hF;
   localparam logic [3:0] REG_SP = 4'hE;
   localparam logic [3:0] REG_CFP = 4'hD;
   localparam logic [3:0] REG_ALP = 4'hC;
   localparam int unsigned MAX_SPEC = 6;
   // specifier mode codes
   localparam logic [3:0] MODE_REG = 4'h0;
   localparam logic [3:0] MODE_DEF = 4'h1;
   localparam logic [3:0] MODE_DEC = 4'h2;
   localparam logic [3:0] MODE_INC = 4'h3;
   localparam logic [3:0] MODE_INCDEF = 4'h4;
   localparam logic [3:0] MODE_DISP = 4'h5;
   localparam logic [3:0] MODE_DISPDEF = 4'h6;
   localparam logic [3:0] MODE_LIT = 4'h7;
   localparam logic [31:0] PTR_SIZE = 32'h0000_0004;
   // status longword fields
   localparam int unsigned USW_W = 16;
   localparam int unsigned CC_N = 3;
   localparam int unsigned CC_Z = 2;
   localparam int unsigned CC_V = 1;
   localparam int unsigned CC_C = 0;
   localparam int unsigned TE_DIV = 7;
   localparam int unsigned TE_FLTU = 6;
   localparam int unsigned TE_INTV = 5;
   localparam int unsigned TE_TRACE = 4;
   localparam logic [31:0] PSL_RST = 32'h0000_0000;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   // exception cause codes
   localparam logic [2:0] EXC_NONE = 3'h0;
   localparam logic [2:0] EXC_INTOVF = 3'h1;
   localparam logic [2:0] EXC_FLTOVF = 3'h2;
   localparam logic [2:0] EXC_DIVZ = 3'h3;
   localparam logic [2:0] EXC_FLTUNF = 3'h4;
   localparam logic [2:0] EXC_TRACE = 3'h5;
   typedef enum logic [1:0] {ST_IDLE, ST_SPEC, ST_PTR, ST_EXEC}
      oag_state_type;
endpackage : oag_pkg

// >>> design/oag_core.sv
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module oag_core (
   // processor clock
   input wire logic core_clk_i,
   // asynchronous reset, active low
   input wire logic rst_b_i,
   // instruction start request from fetch
   // start pulse, taken only while idle
   input wire logic insn_start_i,
   // byte address of the first opcode byte
   input wire logic [31:0] insn_addr_i,
   // opcode length, one or two bytes
   input wire logic [1:0] opc_len_i,
   // number of specifiers that follow
   input wire logic [2:0] spec_cnt_i,
   // one specifier per strobe
   // specifier strobe, taken while ready
   input wire logic spec_vld_i,
   // addressing mode of the specifier
   input wire logic [3:0] spec_mode_i,
   // base register of the specifier
   input wire logic [3:0] spec_reg_i,
   // indexed variant requested
   input wire logic spec_idx_i,
   // index register of an indexed variant
   input wire logic [3:0] spec_idx_reg_i,
   // specifier length in bytes
   input wire logic [2:0] spec_len_i,
   // displacement, already sign extended
   input wire logic [31:0] spec_disp_i,
   // short literal field
   input wire logic [5:0] spec_lit_i,
   // operand size in bytes
   input wire logic [31:0] op_size_i,
   // pointer read answer from memory logic
   // pointer data valid
   input wire logic ptr_vld_i,
   // pointer read from memory
   input wire logic [31:0] ptr_data_i,
   // writeback and result flags
   // register writeback enable
   input wire logic wr_en_i,
   // register written back
   input wire logic [3:0] wr_reg_i,
   // writeback value
   input wire logic [31:0] wr_data_i,
   // condition code update enable
   input wire logic cc_en_i,
   // new condition codes n, z, v, c
   input wire logic [3:0] cc_i,
   // arithmetic exception flags
   input wire logic [3:0] exc_i,
   // trace fault flag
   input wire logic exc_trace_i,
   // conditional branch test strobe
   input wire logic br_test_i,
   // condition code mask of the branch
   input wire logic [3:0] br_cc_i,
   // status longword write strobe
   input wire logic psl_wr_i,
   // privileged write reaches the upper half
   input wire logic psl_priv_i,
   // status longword write data
   input wire logic [31:0] psl_data_i,
   // register read port select
   input wire logic [3:0] rd_reg_i,
   // trap handler address
   input wire logic [31:0] trap_vec_i,
   // end of execution
   input wire logic insn_done_i,
   // register read data, one cycle after select
   output logic [31:0] rd_data_o,
   // ready for a specifier
   output logic spec_rdy_o,
   // operand result valid pulse
   output logic op_vld_o,
   // operand is a memory address
   output logic op_is_mem_o,
   // operand value or address
   output logic [31:0] op_val_o,
   // pointer read request pulse
   output logic ptr_req_o,
   // pointer read address
   output logic [31:0] ptr_addr_o,
   // instruction is executing
   output logic exec_o,
   // program counter view
   output logic [31:0] pc_o,
   // stack pointer view
   output logic [31:0] sp_o,
   // call frame pointer view
   output logic [31:0] cfp_o,
   // argument list pointer view
   output logic [31:0] alp_o,
   // status longword view
   output logic [31:0] psl_o,
   // user status word view
   output logic [15:0] usw_o,
   // branch taken, one cycle after test
   output logic br_take_o,
   // trap pulse
   output logic trap_o,
   // cause of the trap
   output logic [2:0] trap_cause_o,
   // program counter saved at the trap
   output logic [31:0] saved_pc_o,
   // status longword saved at the trap
   output logic [31:0] saved_psl_o
);
   import oag_pkg::*;

   // general register file
   logic [31:0] gpr_ff [REG_N];
   // instruction sequencing state
   oag_state_type state_ff;
   // count of specifiers still to come
   logic [2:0] left_ff; // specifiers still expected
   // address of the pointer being read
   logic [31:0] base_ff; // pending pointer address
   // index added once the pointer arrives
   logic [31:0] idx_ff; // pending scaled index
   // processor status longword
   logic [31:0] psl_ff;
   // register touched by an auto step
   logic [3:0] reg_upd;
   // auto step write enable
   logic reg_upd_en;
   // register value after the auto step
   logic [31:0] reg_upd_val;
   // effective address of the specifier
   logic [31:0] ea;
   // base register value
   logic [31:0] rv;
   // scaled index value, zero when not indexed
   logic [31:0] ix;
   // trap taken at this edge
   logic trap_now;
   // highest priority pending cause
   logic [2:0] cause;

   // register value; pc reads past the consumed specifier bytes
   always_comb begin
      rv = gpr_ff[spec_reg_i];
      ix = gpr_ff[spec_idx_reg_i] * op_size_i;
      if (!spec_idx_i) begin
         ix = 32'h0000_0000;
      end
   end

   // address and register side effect of the presented specifier
   always_comb begin
      ea = 32'h0000_0000;
      reg_upd = spec_reg_i;
      reg_upd_en = 1'b0;
      reg_upd_val = rv;
      unique case (spec_mode_i)
         // register holds the address
         MODE_DEF: ea = rv + ix;
         // step down first, then address
         MODE_DEC: begin
            reg_upd_val = rv - op_size_i;
            reg_upd_en = 1'b1;
            ea = reg_upd_val + ix;
         end
         // address first, then step up
         MODE_INC: begin
            ea = rv + ix;
            reg_upd_val = rv + op_size_i;
            reg_upd_en = 1'b1;
         end
         // pointer address, step by pointer size
         MODE_INCDEF: begin
            ea = rv;
            reg_upd_val = rv + PTR_SIZE;
            reg_upd_en = 1'b1;
         end
         // base plus displacement
         MODE_DISP: ea = rv + spec_disp_i + ix;
         // displacement sum addresses a pointer
         MODE_DISPDEF: ea = rv + spec_disp_i;
         // register and literal need no address
         default: ea = 32'h0000_0000;
      endcase
   end

   // exception cause priority, arithmetic before trace
   always_comb begin
      cause = EXC_NONE;
      if (exc_i[0]) begin
         // integer overflow
         cause = EXC_INTOVF;
      end else if (exc_i[1]) begin
         // floating overflow
         cause = EXC_FLTOVF;
      end else if (exc_i[2]) begin
         // division by zero
         cause = EXC_DIVZ;
      end else if (exc_i[3]) begin
         // floating underflow
         cause = EXC_FLTUNF;
      end else if (exc_trace_i) begin
         // trace fault, lowest priority
         cause = EXC_TRACE;
      end
      // traps are taken only while executing
      trap_now = (cause != EXC_NONE) && (state_ff == ST_EXEC);
   end

   // sequencing of one instruction
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_ff <= ST_IDLE;
         left_ff <= 3'h0;
         base_ff <= REG_RST;
         idx_ff <= REG_RST;
      end else begin
         unique case (state_ff)
            ST_IDLE: if (insn_start_i) begin
               left_ff <= spec_cnt_i;
               state_ff <= (spec_cnt_i == 3'h0) ? ST_EXEC : ST_SPEC;
            end
            ST_SPEC: if (spec_vld_i) begin
               if (spec_mode_i == MODE_INCDEF ||
                   spec_mode_i == MODE_DISPDEF) begin
                  base_ff <= ea;
                  idx_ff <= ix;
                  state_ff <= ST_PTR;
               end else if (left_ff == 3'h1) begin
                  state_ff <= ST_EXEC;
               end
               left_ff <= left_ff - 3'h1;
            end
            ST_PTR: if (ptr_vld_i) begin
               state_ff <= (left_ff == 3'h0) ? ST_EXEC : ST_SPEC;
            end
            ST_EXEC: if (trap_now || insn_done_i) begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // register file writes; one concern, priority trap > spec > wb
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < REG_N; i++) begin
            gpr_ff[i] <= REG_RST;
         end
      end else begin
         if (state_ff == ST_EXEC && wr_en_i) begin
            // sp, frame and argument pointers updated by call logic
            gpr_ff[wr_reg_i] <= wr_data_i;
         end
         if (state_ff == ST_IDLE && insn_start_i) begin
            // pc past opcode while specifiers are consumed
            gpr_ff[REG_PC] <= insn_addr_i + {30'h0, opc_len_i};
         end
         if (state_ff == ST_SPEC && spec_vld_i) begin
            gpr_ff[REG_PC] <= gpr_ff[REG_PC] + {29'h0, spec_len_i};
            if (reg_upd_en && spec_reg_i != REG_PC) begin
               gpr_ff[reg_upd] <= reg_upd_val;
            end
         end
         if (trap_now) begin
            gpr_ff[REG_PC] <= trap_vec_i;
         end else if (state_ff == ST_EXEC && insn_done_i && !wr_en_i) begin
            gpr_ff[REG_PC] <= gpr_ff[REG_PC];
         end
      end
   end

   // status longword: user half and privileged half
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         psl_ff <= PSL_RST;
      end else if (psl_wr_i) begin
         if (psl_priv_i) begin
            psl_ff <= psl_data_i;
         end else begin
            psl_ff[USW_W-1:0] <= psl_data_i[USW_W-1:0];
         end
      end else if (cc_en_i && state_ff == ST_EXEC) begin
         psl_ff[CC_N:CC_C] <= cc_i;
      end
   end

   // operand result and pointer request towards memory logic
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         op_vld_o <= 1'b0;
         op_is_mem_o <= 1'b0;
         op_val_o <= REG_RST;
         ptr_req_o <= 1'b0;
         ptr_addr_o <= REG_RST;
      end else begin
         op_vld_o <= 1'b0;
         ptr_req_o <= 1'b0;
         if (state_ff == ST_SPEC && spec_vld_i) begin
            unique case (spec_mode_i)
               MODE_REG: begin
                  op_vld_o <= 1'b1;
                  op_is_mem_o <= 1'b0;
                  op_val_o <= rv;
               end
               MODE_LIT: begin
                  op_vld_o <= 1'b1;
                  op_is_mem_o <= 1'b0;
                  op_val_o <= {26'h0, spec_lit_i};
               end
               MODE_INCDEF, MODE_DISPDEF: begin
                  ptr_req_o <= 1'b1;
                  ptr_addr_o <= ea;
               end
               default: begin
                  op_vld_o <= 1'b1;
                  op_is_mem_o <= 1'b1;
                  op_val_o <= ea;
               end
            endcase
         end else if (state_ff == ST_PTR && ptr_vld_i) begin
            op_vld_o <= 1'b1;
            op_is_mem_o <= 1'b1;
            op_val_o <= ptr_data_i + idx_ff;
         end
      end
   end

   // execution, branch test and trap reporting
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         exec_o <= 1'b0;
         br_take_o <= 1'b0;
         trap_o <= 1'b0;
         trap_cause_o <= EXC_NONE;
         saved_pc_o <= REG_RST;
         saved_psl_o <= PSL_RST;
         spec_rdy_o <= 1'b0;
         rd_data_o <= REG_RST;
      end else begin
         exec_o <= (state_ff == ST_EXEC) && !trap_now;
         br_take_o <= br_test_i && ((psl_ff[CC_N:CC_C] & br_cc_i) != 4'h0);
         trap_o <= trap_now;
         spec_rdy_o <= (state_ff == ST_SPEC);
         rd_data_o <= gpr_ff[rd_reg_i];
         if (trap_now) begin
            trap_cause_o <= cause;
            saved_pc_o <= gpr_ff[REG_PC];
            saved_psl_o <= psl_ff;
         end
      end
   end

   // architectural views
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pc_o <= REG_RST;
         sp_o <= REG_RST;
         cfp_o <= REG_RST;
         alp_o <= REG_RST;
         psl_o <= PSL_RST;
         usw_o <= 16'h0000;
      end else begin
         pc_o <= gpr_ff[REG_PC];
         sp_o <= gpr_ff[REG_SP];
         cfp_o <= gpr_ff[REG_CFP];
         alp_o <= gpr_ff[REG_ALP];
         psl_o <= psl_ff;
         usw_o <= psl_ff[USW_W-1:0];
      end
   end
endmodule : oag_core

// >>> tb/oag_core_monitor.sv
`timescale 1ns/1ps
module oag_core_monitor
   import oag_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic spec_vld_i,
   input wire logic spec_rdy_o,
   input wire logic [3:0] spec_mode_i,
   input wire logic [5:0] spec_lit_i,
   input wire logic ptr_vld_i,
   input wire logic op_vld_o,
   input wire logic op_is_mem_o,
   input wire logic [31:0] op_val_o,
   input wire logic ptr_req_o,
   input wire logic exec_o,
   input wire logic [3:0] exc_i,
   input wire logic exc_trace_i,
   input wire logic trap_o,
   input wire logic [2:0] trap_cause_o,
   input wire logic [31:0] psl_o,
   input wire logic [15:0] usw_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   logic tk; // specifier taken at this edge
   logic ev; // any exception raised
   assign tk = spec_vld_i && spec_rdy_o;
   assign ev = exc_trace_i || exc_i != 4'h0;
   property p_reg;
      tk && spec_mode_i == MODE_REG |=> op_vld_o && !op_is_mem_o;
   endproperty
   a_reg:
      assert property (p_reg) else $error("mode 0 operand wrong");
   property p_ptr;
      tk && (spec_mode_i == MODE_INCDEF || spec_mode_i == MODE_DISPDEF)
         |=> ptr_req_o && !op_vld_o;
   endproperty
   a_ptr:
      assert property (p_ptr) else $error("no pointer read");
   property p_lit;
      tk && spec_mode_i == MODE_LIT |=> op_vld_o && !op_is_mem_o
         && op_val_o == {26'h0, $past(spec_lit_i)};
   endproperty
   a_lit:
      assert property (p_lit) else $error("literal operand wrong");
   property p_ans;
      ptr_vld_i |=> op_vld_o && op_is_mem_o;
   endproperty
   a_ans:
      assert property (p_ans) else $error("pointer answer lost");
   property p_ovf;
      exec_o && exc_i[0] |=> trap_o && trap_cause_o == EXC_INTOVF;
   endproperty
   a_ovf:
      assert property (p_ovf) else $error("overflow not trapped");
   property p_trc;
      exec_o && exc_trace_i && exc_i == 4'h0
         |=> trap_o && trap_cause_o == EXC_TRACE;
   endproperty
   a_trc:
      assert property (p_trc) else $error("trace not trapped");
   property p_trap;
      trap_o |-> $past(exec_o) && $past(ev);
   endproperty
   a_trap:
      assert property (p_trap) else $error("trap without cause");
   property p_usw;
      usw_o == psl_o[15:0];
   endproperty
   a_usw:
      assert property (p_usw) else $error("user word differs");
endmodule : oag_core_monitor

// >>> tb/oag_mem_model.sv
`timescale 1ns/1ps
// pointer read side, answers after dly_i extra cycles
module oag_mem_model (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   input wire logic [1:0] dly_i,
   output logic vld_o,
   output logic [31:0] data_o
);
   logic busy_ff;
   logic [1:0] cnt_ff;
   logic [31:0] addr_ff;
   // data toggles while released, so a value sampled one cycle late does not match
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_ff <= 1'b0;
         cnt_ff <= 2'h0;
         addr_ff <= 32'h0000_0000;
         vld_o <= 1'b0;
         data_o <= 32'h0000_0000;
      end else begin
         vld_o <= 1'b0;
         data_o <= ~data_o;
         if (req_i) begin
            busy_ff <= 1'b1;
            cnt_ff <= dly_i;
            addr_ff <= addr_i;
         end else if (busy_ff && cnt_ff != 2'h0) begin
            cnt_ff <= cnt_ff - 2'h1;
         end else if (busy_ff) begin
            busy_ff <= 1'b0;
            vld_o <= 1'b1;
            data_o <= addr_ff ^ 32'h5A5A_0F0F;
         end
      end
   end
endmodule : oag_mem_model

// >>> tb/oag_core_bench.sv
`timescale 1ns/1ps
module oag_core_bench;
   import oag_pkg::*;
   logic core_clk_i = 0, rst_b_i = 0, insn_start_i = 0, spec_vld_i = 0;
   logic spec_idx_i = 0, wr_en_i = 0, cc_en_i = 0, exc_trace_i = 0;
   logic br_test_i = 0, psl_wr_i = 0, psl_priv_i = 0, insn_done_i = 0;
   logic [1:0] opc_len_i = 1, dly = 0;
   logic [2:0] spec_cnt_i = 0, spec_len_i = 0, trap_cause_o;
   logic [3:0] spec_mode_i = 0, spec_reg_i = 0, spec_idx_reg_i = 0;
   logic [3:0] wr_reg_i = 0, cc_i = 0, exc_i = 0, br_cc_i = 0, rd_reg_i = 0;
   logic [5:0] spec_lit_i = 0;
   logic [31:0] insn_addr_i = 0, spec_disp_i = 0, op_size_i = 0;
   logic [31:0] wr_data_i = 0, psl_data_i = 0, trap_vec_i = 0;
   logic [31:0] rd_data_o, op_val_o, ptr_addr_o, pc_o, sp_o, cfp_o, alp_o;
   logic [31:0] psl_o, saved_pc_o, saved_psl_o, ptr_data_i;
   logic spec_rdy_o, op_vld_o, op_is_mem_o, ptr_req_o, exec_o, br_take_o;
   logic trap_o, ptr_vld_i;
   logic [15:0] usw_o;
   int miscompares = 0, comparisons = 0, cyc = 0;
   logic [31:0] rf [16]; // expected register file
   logic [31:0] seed = 32'h0000_1045, epc, processor_status_longword;
   oag_core i_dut (.*);
   oag_mem_model i_mem (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
      .req_i(ptr_req_o), .addr_i(ptr_addr_o), .dly_i(dly),
      .vld_o(ptr_vld_i), .data_o(ptr_data_i));
   always #12.5 core_clk_i = ~core_clk_i;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // memory flag and operand value, applies register side effects
   function automatic logic [32:0] exp_op(logic [3:0] m, r, x,
      logic ix, logic [31:0] sz, d, logic [5:0] l);
      logic [31:0] a;
      a = rf[r];
      if (m == MODE_REG) return {1'b0, a};
      if (m == MODE_LIT) return {1'b0, 26'h0, l};
      if (m == MODE_DEC) begin
         rf[r] = a - sz;
         a = rf[r];
      end
      if (m == MODE_INC) rf[r] = a + sz;
      if (m == MODE_INCDEF) rf[r] = a + PTR_SIZE;
      if (m >= MODE_DISP) a = a + d;
      if (m == MODE_INCDEF || m == MODE_DISPDEF) a = a ^ 32'h5A5A_0F0F;
      if (ix) a = a + rf[x] * sz;
      return {1'b1, a};
   endfunction : exp_op
   task automatic chk(input string n, input logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wt(ref logic s);
      int k;
      k = 0;
      do begin
         @(posedge core_clk_i);
         k++;
      end while (s !== 1'b1 && k < 60);
      if (k == 60) chk("wait", 0, 1);
   endtask : wt
   task automatic spec();
      logic [31:0] v, sz, d;
      logic [32:0] e;
      logic [3:0] m, r, x;
      logic ix;
      v = rnd();
      m = {1'b0, v[2:0]};
      r = (v[7:4] == 4'hF) ? 4'hE : v[7:4];
      x = (r == 4'hE) ? 4'hD : r ^ 4'h1;
      ix = v[8] && m != MODE_REG && m != MODE_LIT;
      sz = 32'h0000_0001 << v[10:9];
      d = 32'($signed(v[31:20]));
      wt(spec_rdy_o);
      spec_mode_i <= m;
      spec_reg_i <= r;
      spec_idx_i <= ix;
      spec_idx_reg_i <= x;
      spec_len_i <= {1'b0, v[19:18]} + 3'h1;
      spec_disp_i <= d;
      spec_lit_i <= v[17:12];
      op_size_i <= sz;
      dly <= v[22:21];
      spec_vld_i <= 1'b1;
      epc = epc + {30'h0, v[19:18]} + 32'h1;
      e = exp_op(m, r, x, ix, sz, d, v[17:12]);
      @(posedge core_clk_i);
      spec_vld_i <= 1'b0;
      wt(op_vld_o);
      chk("opval", op_val_o, e[31:0]);
      chk("opmem", 32'(op_is_mem_o), 32'(e[32]));
   endtask : spec
   task automatic insn(input int n);
      logic [31:0] a;
      a = rnd();
      repeat (2) @(posedge core_clk_i);
      insn_addr_i <= a;
      opc_len_i <= {1'b0, a[0]} + 2'h1;
      spec_cnt_i <= 3'(n);
      insn_start_i <= 1'b1;
      epc = a + {31'h0, a[0]} + 32'h1;
      @(posedge core_clk_i);
      insn_start_i <= 1'b0;
      repeat (n) spec();
      wt(exec_o);
      @(posedge core_clk_i);
      chk("pc", pc_o, epc);
   endtask : insn
   task automatic regs();
      for (int r = 0; r < 15; r++) begin
         @(posedge core_clk_i);
         rf[r] = rnd();
         wr_en_i <= 1'b1;
         wr_reg_i <= 4'(r);
         wr_data_i <= rf[r];
      end
      @(posedge core_clk_i);
      wr_en_i <= 1'b0;
      for (int r = 0; r < 15; r++) begin
         rd_reg_i <= 4'(r);
         repeat (2) @(posedge core_clk_i);
         chk("rd", rd_data_o, rf[r]);
      end
      chk("sp", sp_o, rf[14]);
      chk("cfp", cfp_o, rf[13]);
      chk("alp", alp_o, rf[12]);
   endtask : regs
   task automatic stat();
      logic [31:0] v, w;
      v = rnd();
      w = rnd() | 32'h0000_00F0;
      @(posedge core_clk_i);
      psl_wr_i <= 1'b1;
      psl_priv_i <= 1'b1;
      psl_data_i <= v;
      @(posedge core_clk_i);
      psl_priv_i <= 1'b0;
      psl_data_i <= w;
      @(posedge core_clk_i);
      psl_wr_i <= 1'b0;
      cc_en_i <= 1'b1;
      cc_i <= v[7:4];
      @(posedge core_clk_i);
      cc_en_i <= 1'b0;
      br_test_i <= 1'b1;
      br_cc_i <= w[11:8];
      @(posedge core_clk_i);
      br_test_i <= 1'b0;
      @(posedge core_clk_i);
      chk("br", 32'(br_take_o), 32'(|(w[11:8] & v[7:4])));
      processor_status_longword = {v[31:16], w[15:4], v[7:4]};
      @(posedge core_clk_i);
      chk("psl", psl_o, processor_status_longword);
   endtask : stat
   task automatic fin();
      @(posedge core_clk_i);
      insn_done_i <= 1'b1;
      @(posedge core_clk_i);
      insn_done_i <= 1'b0;
   endtask : fin
   task automatic end_sim();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   // hang guard
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc > 10000) begin
         miscompares++;
         end_sim();
      end
   end
   initial begin
      repeat (10) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      for (int t = 0; t < 6; t++) begin
         insn(0);
         regs();
         stat();
         fin();
         for (int i = 0; i < 8; i++) begin
            insn(i % 7);
            fin();
         end
         $display("round %0d done", t);
      end
      // every cause, lower ones raised together for priority
      for (int k = 0; k < 5; k++) begin
         insn(0);
         trap_vec_i <= rnd();
         exc_i <= 4'(4'hF << k);
         exc_trace_i <= 1'b1;
         @(posedge core_clk_i);
         exc_i <= 4'h0;
         exc_trace_i <= 1'b0;
         wt(trap_o);
         chk("cause", 32'(trap_cause_o), 32'(k + 1));
         chk("spsl", saved_psl_o, processor_status_longword);
         chk("spc", saved_pc_o, epc);
         repeat (2) @(posedge core_clk_i);
         chk("tpc", pc_o, trap_vec_i);
      end
      $display("exceptions done");
      end_sim();
   end
endmodule : oag_core_bench
bind oag_core oag_core_monitor i_mon (.*);
